/* File: bench/fpm_framer_model.sv */
// Framer model: makes the transmit clock and the unipolar transmit data.
// Assumes the bench starts it by run_i and clocks it from the master clock.
`timescale 1ns/10ps
module fpm_framer_model (
  // Control.
  input  wire logic mclk_i,
  input  wire logic run_i,
  input  wire logic data_i,
  // Framer pins.
  output logic      tx_clk_o,
  output logic      tx_data_o
);
  int unsigned cnt_r;
  initial begin
    tx_clk_o  = 1'b0;
    tx_data_o = 1'b0;
    cnt_r     = 0;
  end
  // The clock stands still while run_i is low; data moves at its fall.
  always @(negedge mclk_i) begin
    if (!run_i) begin
      cnt_r    <= 0;
      tx_clk_o <= 1'b0;
    end else if (cnt_r == 19) begin
      cnt_r    <= 0;
      tx_clk_o <= !tx_clk_o;
      if (tx_clk_o) tx_data_o <= data_i;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
endmodule : fpm_framer_model

/* File: bench/fpm_port_tb_top.sv */
// Testbench for one framer port channel.
// Assumes the framer model drives the transmit and recovered clocks.
`timescale 1ns/10ps
module fpm_port_tb_top;
  import fpm_pkg::*;
  logic mclk = 0, nrst_n = 0, mode = 0, txp = 0, run = 0, mdata = 0;
  logic sig_loss = 0, mlev = 0, stuck = 0, edge_sel = 0, txc, tdata;
  logic [1:0] rx = 2'h0, prev;
  fpm_pulse_t tx_o;
  logic rxp, rxn, rclk, oe_n, uni;
  int bad_count = 0, n_compared = 0, cyc = 0;
  initial forever #2 mclk = !mclk;
  fpm_framer_model u_frm (.mclk_i(mclk), .run_i(run), .data_i(mdata),
    .tx_clk_o(txc), .tx_data_o(tdata));
  fpm_port u_dut (.MCLK_I(mclk), .NRST_I(nrst_n),
    .TX_NEGATIVE_OR_MODE_SELECT_I(mode),
    .TX_POSITIVE_PULSE_IN_I(run ? tdata : txp), .TX_CLOCK_IN_I(txc),
    .RX_LINE_PAIR_I(rx), .RX_RECOVERED_CLOCK_I(txc),
    .LOSS_OF_SIGNAL_I(sig_loss), .MASTER_CLOCK_LEVEL_I(mlev),
    .MASTER_CLOCK_STUCK_I(stuck), .CLOCK_EDGE_SELECT_I(edge_sel),
    .TX_LINE_PAIR_O(tx_o), .RX_POSITIVE_PULSE_OUT_O(rxp),
    .RX_NEGATIVE_PULSE_OUT_O(rxn), .RX_CLOCK_O(rclk),
    .RX_CLOCK_OE_N_O(oe_n), .MODE_UNIPOLAR_O(uni));
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask : wt
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t: got %b want %b", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  // A short high pulse must not reach unipolar; a long one must.
  task automatic t_mode;
    mode = 1'b1;
    wt(12);
    mode = 1'b0;
    repeat (20) begin
      wt(1);
      chk({1'b0, uni}, 2'h0);
    end
    mode = 1'b1;
    wt(30);
    chk({1'b0, uni}, 2'h1);
    mode = 1'b0;
    wt(8);
    chk({1'b0, uni}, 2'h0);
    $display("test mode done");
  endtask : t_mode
  task automatic t_btx;
    for (int i = 0; i < 3; i++) begin
      {txp, mode} = 2'(i);
      wt(8);
      chk(tx_o, 2'(i));
    end
    {txp, mode} = 2'h0;
    chk({1'b0, uni}, 2'h0);
    $display("test bipolar transmit done");
  endtask : t_btx
  task automatic t_utx;
    mode = 1'b1;
    mdata = 1'b1;
    run = 1'b1;
    prev = 2'h0;
    // The first clock rise comes before the filter has chosen unipolar.
    wt(30);
    chk({1'b0, uni}, 2'h1);
    repeat (5) begin
      @(posedge txc);
      wt(10);
      chk({1'b0, ^tx_o}, 2'h1);
      if (prev !== 2'h0) chk(tx_o, ~prev);
      else chk(tx_o, 2'h2);
      prev = tx_o;
    end
    mdata = 1'b0;
    repeat (2) @(posedge txc);
    wt(10);
    chk(tx_o, 2'h0);
    $display("test unipolar transmit done");
  endtask : t_utx
  task automatic t_rx(input logic [1:0] pat, input logic [1:0] exp);
    if (edge_sel) @(posedge txc);
    else @(negedge txc);
    wt(1);
    rx = pat;
    if (edge_sel) @(negedge txc);
    else @(posedge txc);
    wt(10);
    chk({rxp, rxn}, exp);
  endtask : t_rx
  task automatic t_urx;
    t_rx(2'h2, 2'h2);
    t_rx(2'h1, 2'h2);
    t_rx(2'h2, 2'h2);
    t_rx(2'h2, 2'h3);
    edge_sel = 1'b1;
    t_rx(2'h1, 2'h2);
    edge_sel = 1'b0;
    mode = 1'b0;
    wt(8);
    t_rx(2'h1, 2'h1);
    t_rx(2'h2, 2'h2);
    rx = 2'h0;
    $display("test receive done");
  endtask : t_urx
  task automatic t_rclk;
    sig_loss = 1'b1;
    mlev = 1'b1;
    wt(8);
    chk({oe_n, rclk}, 2'h1);
    mlev = 1'b0;
    wt(8);
    chk({oe_n, rclk}, 2'h0);
    sig_loss = 1'b0;
    @(posedge txc);
    wt(8);
    chk({oe_n, rclk}, 2'h1);
    stuck = 1'b1;
    wt(8);
    chk({oe_n, rclk}, 2'h2);
    t_rx(2'h2, 2'h2);
    mlev = 1'b1;
    wt(8);
    chk({oe_n, rclk}, 2'h1);
    t_rx(2'h3, 2'h3);
    chk({oe_n, rclk}, 2'h0);
    run = 1'b0;
    rx = 2'h0;
    $display("test receive clock done");
  endtask : t_rclk
  // Whole run is near 900 cycles; the ceiling leaves a wide margin.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    wt(8);
    chk({oe_n, uni}, 2'h2);
    nrst_n = 1'b1;
    wt(8);
    t_mode();
    t_btx();
    t_utx();
    t_urx();
    t_rclk();
    end_of_test();
  end
endmodule : fpm_port_tb_top

/* File: hdl/fpm_defs.svh */
// Constants for the framer port polarity mode block.
// Assumes inclusion by bare name from hdl/ files.
`ifndef FPM_DEFS_SVH
`define FPM_DEFS_SVH
`define FPM_MODE_FILTER_CYCLES 16
`define FPM_SYNC_STAGES        3
`define FPM_CNT_W              5
`endif

/* File: hdl/fpm_pkg.sv */
// Types for the framer port polarity mode block.
// Assumes fpm_defs.svh is on the include path.
package fpm_pkg;
  typedef enum logic {FPM_BIPOLAR, FPM_UNIPOLAR} fpm_mode_t;
  typedef struct packed {
    logic pos;
    logic neg;
  } fpm_pulse_t;
  typedef enum logic [1:0] {
    FPM_RCLK_RECOVERED,
    FPM_RCLK_MASTER,
    FPM_RCLK_HIGHZ,
    FPM_RCLK_XOR
  } fpm_rclk_sel_t;
endpackage : fpm_pkg

/* File: hdl/fpm_port.sv */
// Overview of operation
// - Mode pin low selects bipolar transfer with positive, negative lines.
// - Unipolar only after mode pin high more than 16 master clocks.
// - One mode pin sets both receive and transmit arrangement.
// - In bipolar, negative transmit input one emits a negative line pulse.
// - In bipolar, positive transmit input one emits a positive line pulse.
// - Unipolar transmit data is taken on the transmit clock edge.
// - Unipolar mark polarity is chosen here by alternating marks.
// - Unipolar violation output stays low without a code violation.
// - Unipolar violation output goes high on a code violation.
// - Receive clock is recovered clock, master clock during signal loss.
// - Master clock held low gives high impedance receive clock.
// - Master clock held high gives XOR of receive pulse outputs.
// - Unipolar receive data appears on the shared positive pin.
// - Bipolar receive outputs mark each negative and positive pulse.
// - Unipolar decodes AMI internally; bipolar leaves decoding to framer.
// - Clock edge select chooses the receive clock edge for output data.
//
// One channel of the framer port, sampled on MCLK_I at 250 MHz.
// Assumes line pulses and clocks arrive asynchronously and slowly.
`timescale 1ns/10ps
`include "fpm_defs.svh"
module fpm_port (
  // Clock and reset.
  input  wire logic              MCLK_I,
  input  wire logic              NRST_I,
  // Framer transmit side.
  input  wire logic              TX_NEGATIVE_OR_MODE_SELECT_I,
  input  wire logic              TX_POSITIVE_PULSE_IN_I,
  input  wire logic              TX_CLOCK_IN_I,
  // Line side.
  input  wire fpm_pkg::fpm_pulse_t RX_LINE_PAIR_I,
  input  wire logic              RX_RECOVERED_CLOCK_I,
  input  wire logic              LOSS_OF_SIGNAL_I,
  input  wire logic              MASTER_CLOCK_LEVEL_I,
  input  wire logic              MASTER_CLOCK_STUCK_I,
  input  wire logic              CLOCK_EDGE_SELECT_I,
  output fpm_pkg::fpm_pulse_t    TX_LINE_PAIR_O,
  // Framer receive side.
  output logic                   RX_POSITIVE_PULSE_OUT_O,
  output logic                   RX_NEGATIVE_PULSE_OUT_O,
  output logic                   RX_CLOCK_O,
  output logic                   RX_CLOCK_OE_N_O,
  output logic                   MODE_UNIPOLAR_O
);
  import fpm_pkg::*;

  logic rst_a_r;
  logic rst_n_r;
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_a_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_n_r <= rst_a_r;
    end
  end

  logic mode_pin_s;
  logic txp_s;
  logic txc_s;
  logic rxp_s;
  logic rxn_s;
  logic rrec_s;
  logic sig_loss_s;
  logic mlvl_s;
  logic mstk_s;
  logic edge_sel_s;
  logic [9:0] raw_in;
  logic [9:0] syn_out;
  assign raw_in = {TX_NEGATIVE_OR_MODE_SELECT_I, TX_POSITIVE_PULSE_IN_I,
                   TX_CLOCK_IN_I, RX_LINE_PAIR_I.pos, RX_LINE_PAIR_I.neg,
                   RX_RECOVERED_CLOCK_I, LOSS_OF_SIGNAL_I,
                   MASTER_CLOCK_LEVEL_I, MASTER_CLOCK_STUCK_I,
                   CLOCK_EDGE_SELECT_I};
  for (genvar g = 0; g < 10; g++) begin : g_sync
    fpm_sync u_sync (
      .clk_i   (MCLK_I),
      .rst_n_i (rst_n_r),
      .d_i     (raw_in[g]),
      .q_o     (syn_out[g])
    );
  end
  assign {mode_pin_s, txp_s, txc_s, rxp_s, rxn_s, rrec_s, sig_loss_s,
          mlvl_s, mstk_s, edge_sel_s} = syn_out;

  // Mode filter: a glitch high must not flip the whole channel.
  logic [`FPM_CNT_W-1:0] hi_cnt_r;
  logic [`FPM_CNT_W-1:0] hi_cnt_nxt;
  fpm_mode_t             mode_r;
  fpm_mode_t             mode_nxt;
  logic                  hi_done;
  assign hi_done = hi_cnt_r > `FPM_CNT_W'(`FPM_MODE_FILTER_CYCLES);
  assign hi_cnt_nxt = !mode_pin_s ? '0 :
                      hi_done ? hi_cnt_r : hi_cnt_r + 1'b1;
  assign mode_nxt = !mode_pin_s ? FPM_BIPOLAR :
                    hi_done ? FPM_UNIPOLAR : mode_r;
  always_ff @(posedge MCLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hi_cnt_r <= '0;
      mode_r   <= FPM_BIPOLAR;
    end else begin
      hi_cnt_r <= hi_cnt_nxt;
      mode_r   <= mode_nxt;
    end
  end
  logic uni;
  assign uni = (mode_r == FPM_UNIPOLAR);

  // Edge detection on the synchronised clocks.
  logic txc_d_r;
  logic rrec_d_r;
  logic txc_rise;
  logic rrec_edge;
  assign txc_rise  = txc_s && !txc_d_r;
  assign rrec_edge = (rrec_s != rrec_d_r) && (rrec_s != edge_sel_s);

  // Transmit: bipolar passes pulses, unipolar uses alternate mark inversion.
  logic       ami_pol_r;
  fpm_pulse_t tx_r;
  fpm_pulse_t tx_nxt;
  logic       tx_mark;
  assign tx_mark = txp_s;
  always_comb begin
    tx_nxt = tx_r;
    if (!uni) begin
      tx_nxt.pos = txp_s;
      tx_nxt.neg = mode_pin_s;
    end else if (txc_rise) begin
      tx_nxt.pos = tx_mark && !ami_pol_r;
      tx_nxt.neg = tx_mark && ami_pol_r;
    end else if (tx_r.pos && tx_r.neg) begin
      // A bipolar pair left over from the mode change is no legal mark.
      tx_nxt = '0;
    end
  end

  // Receive: unipolar decodes marks and flags same-polarity repeats.
  logic last_neg_r;
  logic rx_pos_r;
  logic rx_neg_r;
  logic viol;
  logic mark_in;
  assign mark_in = rxp_s || rxn_s;
  assign viol = mark_in && (rxn_s == last_neg_r);
  always_ff @(posedge MCLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      txc_d_r    <= 1'b0;
      rrec_d_r   <= 1'b0;
      ami_pol_r  <= 1'b0;
      tx_r       <= '0;
      last_neg_r <= 1'b1;
      rx_pos_r   <= 1'b0;
      rx_neg_r   <= 1'b0;
    end else begin
      txc_d_r  <= txc_s;
      rrec_d_r <= rrec_s;
      tx_r     <= tx_nxt;
      if (uni && txc_rise && tx_mark) begin
        ami_pol_r <= !ami_pol_r;
      end
      if (rrec_edge) begin
        if (uni) begin
          rx_pos_r <= mark_in;
          rx_neg_r <= viol;
          if (mark_in) begin
            last_neg_r <= rxn_s;
          end
        end else begin
          rx_pos_r <= rxp_s;
          rx_neg_r <= rxn_s;
        end
      end
    end
  end

  // Receive clock source selection.
  fpm_rclk_sel_t rsel;
  logic          rclk_nxt;
  logic          rclk_r;
  logic          roe_n_r;
  assign rsel = (mstk_s && !mlvl_s) ? FPM_RCLK_HIGHZ :
                (mstk_s && mlvl_s)  ? FPM_RCLK_XOR :
                sig_loss_s ? FPM_RCLK_MASTER : FPM_RCLK_RECOVERED;
  always_comb begin
    unique case (rsel)
      FPM_RCLK_RECOVERED: rclk_nxt = rrec_s;
      FPM_RCLK_MASTER:    rclk_nxt = mlvl_s;
      FPM_RCLK_HIGHZ:     rclk_nxt = 1'b0;
      FPM_RCLK_XOR:       rclk_nxt = rx_pos_r ^ rx_neg_r;
    endcase
  end
  always_ff @(posedge MCLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rclk_r  <= 1'b0;
      roe_n_r <= 1'b1;
    end else begin
      rclk_r  <= rclk_nxt;
      roe_n_r <= (rsel == FPM_RCLK_HIGHZ);
    end
  end

  assign TX_LINE_PAIR_O          = tx_r;
  assign RX_POSITIVE_PULSE_OUT_O = rx_pos_r;
  assign RX_NEGATIVE_PULSE_OUT_O = rx_neg_r;
  assign RX_CLOCK_O              = rclk_r;
  assign RX_CLOCK_OE_N_O         = roe_n_r;
  assign MODE_UNIPOLAR_O         = mode_r;

  property p_bipolar_on_low;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      !mode_pin_s |=> !MODE_UNIPOLAR_O;
  endproperty
  a_bipolar_on_low: assert property (p_bipolar_on_low)
    else $error("Mode not bipolar after low sample.");

  sequence s_high17;
    mode_pin_s [*8] ##1 mode_pin_s [*8] ##1 mode_pin_s;
  endsequence
  property p_uni_after_filter;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      s_high17 ##1 mode_pin_s |=> MODE_UNIPOLAR_O;
  endproperty
  a_uni_after_filter: assert property (p_uni_after_filter)
    else $error("Unipolar not selected after filter.");

  property p_no_early_uni;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      $rose(MODE_UNIPOLAR_O) |-> $past(hi_cnt_r) ==
                                 `FPM_CNT_W'(`FPM_MODE_FILTER_CYCLES + 1);
  endproperty
  a_no_early_uni: assert property (p_no_early_uni)
    else $error("Unipolar selected too early.");

  property p_bip_pos;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      !uni && txp_s |=> TX_LINE_PAIR_O.pos;
  endproperty
  a_bip_pos: assert property (p_bip_pos)
    else $error("Positive pulse not emitted.");

  property p_bip_neg;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      !uni && mode_pin_s |=> TX_LINE_PAIR_O.neg;
  endproperty
  a_bip_neg: assert property (p_bip_neg)
    else $error("Negative pulse not emitted.");

  property p_uni_not_both;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      uni |=> !(TX_LINE_PAIR_O.pos && TX_LINE_PAIR_O.neg);
  endproperty
  a_uni_not_both: assert property (p_uni_not_both)
    else $error("Both line polarities driven.");

  property p_viol_low;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      uni && rrec_edge && !viol |=> !RX_NEGATIVE_PULSE_OUT_O;
  endproperty
  a_viol_low: assert property (p_viol_low)
    else $error("Violation flag high without cause.");

  property p_viol_high;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      uni && rrec_edge && viol |=> RX_NEGATIVE_PULSE_OUT_O;
  endproperty
  a_viol_high: assert property (p_viol_high)
    else $error("Violation flag missed.");

  property p_highz;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      mstk_s && !mlvl_s |=> RX_CLOCK_OE_N_O;
  endproperty
  a_highz: assert property (p_highz)
    else $error("Receive clock driven while held low.");

  property p_los_master;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      !mstk_s && sig_loss_s |=> RX_CLOCK_O == $past(mlvl_s);
  endproperty
  a_los_master: assert property (p_los_master)
    else $error("Master clock not substituted.");
endmodule : fpm_port

/* File: hdl/fpm_sync.sv */
// Three-stage synchroniser with agreement of the last two stages.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/10ps
module fpm_sync (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Data.
  input  wire logic d_i,
  output logic      q_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic q_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q_r  <= 1'b0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_r <= s3_r;
      end
    end
  end
  assign q_o = q_r;
endmodule : fpm_sync
